/* design/ckss_pkg.sv */
package ckss_pkg;

	// ----------------------------------------------------------------
	// Timing: watchdog oscillator paces the long reset delays
	// ----------------------------------------------------------------
	localparam int WDT_OSC_KHZ   = 128;
	localparam int DLY_4P1MS_US  = 4100;
	localparam int DLY_4MS_US    = 4000;
	localparam int DLY_64MS_US   = 64000;
	localparam int DLY_65MS_US   = 65000;
	// Least times, so round up to whole watchdog ticks
	localparam int TICKS_4P1MS   = (DLY_4P1MS_US * WDT_OSC_KHZ + 999) / 1000;
	localparam int TICKS_4MS     = (DLY_4MS_US * WDT_OSC_KHZ + 999) / 1000;
	localparam int TICKS_64MS    = (DLY_64MS_US * WDT_OSC_KHZ + 999) / 1000;
	localparam int TICKS_65MS    = (DLY_65MS_US * WDT_OSC_KHZ + 999) / 1000;
	localparam int MS_CNT_W      = 14;
	localparam logic [3:0] RESET_CK = 4'he;
	localparam logic [3:0] WAKE_CK  = 4'h6;

	// ----------------------------------------------------------------
	// Fuse codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_EXT  = 4'h0;
	localparam logic [3:0] CODE_RC   = 4'h2;
	localparam logic [3:0] CODE_LP   = 4'h3;
	localparam logic [1:0] STUP_BOD  = 2'h0;
	localparam logic [1:0] STUP_FAST = 2'h1;
	localparam logic [1:0] STUP_SLOW = 2'h2;
	localparam logic [1:0] STUP_RSVD = 2'h3;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TRIM   = 8'h00;
	localparam logic [7:0] ADDR_PRESC  = 8'h04;
	localparam logic [7:0] ADDR_ASYNC  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CALIB  = 8'h10;
	localparam int         PRESC_CE_BIT    = 7;
	localparam logic [3:0] PRESC_DIV1      = 4'h0;
	localparam logic [3:0] PRESC_DIV8      = 4'h3;
	localparam logic [3:0] PRESC_MAX       = 4'h8;
	localparam logic [2:0] PRESC_CE_CYCLES = 3'h4;
	localparam int         ASYNC_AS_BIT    = 5;
	localparam int         ASYNC_EXT_BIT   = 6;
	localparam logic [7:0] ASYNC_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum {ST_RESET, ST_DLY_MS, ST_DLY_CK, ST_RUN, ST_SLEEP, ST_WAKE} ckss_state_e;
	typedef enum logic [1:0] {SRC_RC, SRC_LP, SRC_EXT} ckss_src_e;

	// Fuse bit set means programmed
	typedef struct packed {
		logic [3:0] src_sel;
		logic [1:0] stup;
		logic       div8;
		logic       rst_dis;
		logic       clk_out;
	} ckss_fuse_s;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ckss_wb_req_s;

endpackage

/* design/ckss_sync.sv */
module ckss_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i, // System clock
	input  wire logic [W-1:0] d_i,   // Asynchronous levels
	output logic      [W-1:0] q_o    // Synchronised levels
);
	logic [W-1:0] meta_r;

	// Two stages; the first is read only by the second
	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_o    <= meta_r;
	end
endmodule

/* design/ckss_clk_div.sv */
module ckss_clk_div
	import ckss_pkg::*;
(
	input  wire logic       clk_i,     // System clock
	input  wire logic       por_i,     // Power-on reset only
	input  wire logic       src_lvl_i, // Selected source level
	input  wire logic       src_rise_i,// Source rising edge
	input  wire logic [3:0] div_sel_i, // Division exponent
	output logic            clk_o      // Divided clock level
);
	logic [7:0] cnt_r;

	// Not cleared by chip reset so the clock keeps running during it
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			cnt_r <= 8'h00;
		end else if (src_rise_i) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Bit n-1 of a rising-edge counter has period 2^n source cycles
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			clk_o <= 1'b0;
		end else if (div_sel_i == PRESC_DIV1 || div_sel_i > PRESC_MAX) begin
			clk_o <= src_lvl_i;
		end else begin
			clk_o <= cnt_r[3'(div_sel_i - 4'h1)];
		end
	end
endmodule

/* design/ckss_top.sv */
// Functional notes
// RULE1: Internal RC gives nominal 8.0MHz, 7.3 to 8.1 MHz, no external parts.
// RULE2: Source code 0010 selects the RC oscillator; shipped default.
// RULE3: During reset the 3V factory trim loads into the trim register.
// RULE4: Software may write any trim value, e.g. the 5V byte, at run time.
// RULE5: Watchdog oscillator still times reset time-out with RC as clock.
// RULE6: RC source: wake 6 CK; reset 14CK, +4.1ms, +65ms; code 11 reserved.
// RULE7: Reset-pin-disable fuse stretches a bare 14CK reset delay to 14CK + 4.1ms.
// RULE8: Source code 0011 selects the low-accuracy 128kHz oscillator.
// RULE9: 128kHz source: wake 6 CK; reset 14CK, +4ms, +64ms; code 11 reserved.
// RULE10: Source code 0000 routes external clock, 0 to 16MHz, from crystal input.
// RULE11: External source: wake 6 CK; reset 14CK, +4.1ms, +65ms; 11 reserved.
// RULE12: External clock may not jump over 2% per cycle unless held in reset.
// RULE13: Clock-output fuse drives system clock on its pin, overriding port use.
// RULE14: Clock output keeps toggling while the device is held in reset.
// RULE15: Clock output carries the prescaler-divided system clock.
// RULE16: Timer oscillator shares crystal pins; only with RC system clock.
// RULE17: External-clock select bit makes timer pin one take an external clock.
// RULE18: Divide-by-eight fuse divides internal clock by 8; shipped programmed.
// RULE19: Prescaler select resets to 0011 with that fuse, else 0000.
module ckss_top
	import ckss_pkg::*;
#(
	parameter int T_64MS_TICKS = TICKS_64MS, // Long delay, 128kHz source
	parameter int T_65MS_TICKS = TICKS_65MS  // Long delay, RC and external
) (
	input  wire logic         clk_i,                         // 100 MHz system clock
	input  wire logic         rst_i,                         // Chip reset, sync high
	input  wire logic         por_i,                         // Power-on reset, sync high
	input  wire ckss_fuse_s   fuses_i,                       // Fuse settings
	input  wire logic [7:0]   factory_trim_3v_i,             // Stored 3V trim
	input  wire logic [7:0]   factory_trim_5v_i,             // Stored 5V trim
	input  wire logic         rc_osc_i,                      // RC oscillator level
	input  wire logic         lp_osc_i,                      // 128kHz oscillator level
	input  wire logic         crystal_input_pin_i,           // External clock pin
	input  wire logic         wdt_osc_i,                     // Watchdog oscillator level
	input  wire logic         power_down_i,                  // Core asks for power-down
	input  wire ckss_wb_req_s wb_i,                          // Wishbone request
	output logic [31:0]       wb_dat_o,                      // Wishbone read data
	output logic              wb_ack_o,                      // Wishbone ack
	output logic [7:0]        rc_trim_register_o,            // Trim to RC oscillator
	output logic              rc_osc_en_o,                   // RC oscillator enable
	output logic              lp_osc_en_o,                   // 128kHz oscillator enable
	output logic              sys_clk_o,                     // Divided system clock
	output logic              core_reset_o,                  // Core held in reset
	output logic              core_clk_en_o,                 // Core clock running
	output logic              clock_output_pin_o,            // Clock output pin value
	output logic              clock_output_pin_oe_o,         // Clock output pin enable
	output logic              timer_osc_en_o,                // Timer oscillator enable
	output logic              timer_external_clock_select_o, // Timer pin one takes clock
	output logic              fuse_error_o                   // Reserved fuse code seen
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic ckss_src_e src_decode(input logic [3:0] code);
		unique case (code)
			CODE_LP:   return SRC_LP;
			CODE_EXT:  return SRC_EXT;
			default:   return SRC_RC;
		endcase
	endfunction

	function automatic logic [MS_CNT_W-1:0] ms_ticks(input ckss_src_e src, input ckss_fuse_s f);
		logic lp;
		lp = (src == SRC_LP);
		unique case (f.stup)
			STUP_BOD:  return f.rst_dis ? MS_CNT_W'(TICKS_4P1MS) : '0;
			STUP_FAST: return lp ? MS_CNT_W'(TICKS_4MS) : MS_CNT_W'(TICKS_4P1MS);
			default:  return lp ? MS_CNT_W'(T_64MS_TICKS) : MS_CNT_W'(T_65MS_TICKS);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Fuse capture and source selection
	// ----------------------------------------------------------------
	ckss_fuse_s  fuses_r;
	ckss_src_e   src;
	logic [3:0]  osc_sync;
	logic        src_lvl;
	logic        src_prev_r;
	logic        src_rise;
	logic        wdt_prev_r;
	logic        wdt_rise;

	// Fuses are only sampled at power-on
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			fuses_r <= fuses_i;
		end
	end

	// RULE2: code 0010 picks RC
	// RULE8: code 0011 picks 128kHz
	// RULE10: code 0000 picks external clock
	assign src = src_decode(fuses_r.src_sel);
	assign fuse_error_o = !(fuses_r.src_sel inside {CODE_EXT, CODE_RC, CODE_LP}) || fuses_r.stup == STUP_RSVD;

	// RULE1: RC enabled only while it is the source, saving power otherwise
	assign rc_osc_en_o = (src == SRC_RC);
	assign lp_osc_en_o = (src == SRC_LP);

	// All oscillator levels come from outside this clock domain
	ckss_sync #(.W(4)) u_osc_sync (
		.clk_i (clk_i),
		.d_i   ({wdt_osc_i, crystal_input_pin_i, lp_osc_i, rc_osc_i}),
		.q_o   (osc_sync)
	);

	// RULE12: a jumpy external clock is the driver's problem, hence no filter here
	always_comb begin
		unique case (src)
			SRC_LP:  src_lvl = osc_sync[1];
			SRC_EXT: src_lvl = osc_sync[2];
			default: src_lvl = osc_sync[0];
		endcase
	end

	// Edge detectors on synchronised levels
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			src_prev_r <= 1'b0;
			wdt_prev_r <= 1'b0;
		end else begin
			src_prev_r <= src_lvl;
			wdt_prev_r <= osc_sync[3];
		end
	end
	assign src_rise = src_lvl & ~src_prev_r;
	assign wdt_rise = osc_sync[3] & ~wdt_prev_r;

	// ----------------------------------------------------------------
	// Start-up sequencer
	// ----------------------------------------------------------------
	ckss_state_e          state_r;
	logic [MS_CNT_W-1:0]  ms_cnt_r;
	logic [MS_CNT_W-1:0]  ms_target_r;
	logic [3:0]           ck_cnt_r;

	// RULE5: long delay counts watchdog ticks, not the system source
	// RULE6: RC start-up codes
	// RULE9: 128kHz start-up codes
	// RULE11: external start-up codes
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			state_r  <= ST_RESET;
			ms_cnt_r <= '0;
			ck_cnt_r <= 4'h0;
		end else begin
			unique case (state_r)
				ST_RESET: begin
					ms_cnt_r <= '0;
					ck_cnt_r <= 4'h0;
					state_r  <= (ms_target_r == '0) ? ST_DLY_CK : ST_DLY_MS;
				end
				ST_DLY_MS: begin
					if (wdt_rise) begin
						ms_cnt_r <= ms_cnt_r + 1'b1;
						if (ms_cnt_r == ms_target_r - 1'b1) begin
							state_r <= ST_DLY_CK;
						end
					end
				end
				ST_DLY_CK: begin
					if (src_rise) begin
						ck_cnt_r <= ck_cnt_r + 4'h1;
						if (ck_cnt_r == RESET_CK - 4'h1) begin
							state_r <= ST_RUN;
						end
					end
				end
				ST_RUN: begin
					if (power_down_i) begin
						state_r <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					ck_cnt_r <= 4'h0;
					if (!power_down_i) begin
						state_r <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (src_rise) begin
						ck_cnt_r <= ck_cnt_r + 4'h1;
						if (ck_cnt_r == WAKE_CK - 4'h1) begin
							state_r <= ST_RUN;
						end
					end
				end
			endcase
		end
	end

	// RULE7: bare 14CK stretched when the reset pin is disabled
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ms_target_r <= ms_ticks(src_decode(por_i ? fuses_i.src_sel : fuses_r.src_sel),
				por_i ? fuses_i : fuses_r);
		end
	end

	assign core_reset_o  = (state_r == ST_RESET) || (state_r == ST_DLY_MS) || (state_r == ST_DLY_CK);
	assign core_clk_en_o = (state_r == ST_RUN);

	// ----------------------------------------------------------------
	// Wishbone slave and registers
	// ----------------------------------------------------------------
	logic       ack_r;
	logic       req;
	logic       wr;
	logic [7:0] trim_r;
	logic [3:0] presc_r;
	logic [2:0] ce_cnt_r;
	logic [7:0] async_r;
	logic [7:0] status;

	assign req = wb_i.cyc & wb_i.stb;
	// Writes land at the edge where ack is sampled high
	assign wr = req & wb_i.we & ack_r & wb_i.sel[0];
	assign wb_ack_o = ack_r;

	// One wait state; ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// RULE3: reset loads the 3V factory trim
	// RULE4: software may overwrite it freely
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			trim_r <= factory_trim_3v_i;
		end else if (wr && wb_i.adr == ADDR_TRIM) begin
			trim_r <= wb_i.dat[7:0];
		end
	end
	assign rc_trim_register_o = trim_r;

	// RULE18: divide-by-eight fuse sets a divide by 8
	// RULE19: prescaler reset value follows that fuse
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			presc_r <= fuses_i.div8 ? PRESC_DIV8 : PRESC_DIV1;
		end else if (rst_i) begin
			presc_r <= fuses_r.div8 ? PRESC_DIV8 : PRESC_DIV1;
		end else if (wr && wb_i.adr == ADDR_PRESC && ce_cnt_r != 3'h0 && !wb_i.dat[PRESC_CE_BIT]
			&& wb_i.dat[3:0] <= PRESC_MAX) begin
			presc_r <= wb_i.dat[3:0];
		end
	end

	// Change enable lasts four cycles; a rewrite neither extends nor clears it
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			ce_cnt_r <= 3'h0;
		end else if (wr && wb_i.adr == ADDR_PRESC && ce_cnt_r == 3'h0
			&& wb_i.dat[7:0] == 8'(1 << PRESC_CE_BIT)) begin
			ce_cnt_r <= PRESC_CE_CYCLES;
		end else if (wr && wb_i.adr == ADDR_PRESC && !wb_i.dat[PRESC_CE_BIT]) begin
			ce_cnt_r <= 3'h0;
		end else if (ce_cnt_r != 3'h0) begin
			ce_cnt_r <= ce_cnt_r - 3'h1;
		end
	end

	// RULE17: external-clock select bit for timer pin one
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			async_r <= ASYNC_RESET;
		end else if (wr && wb_i.adr == ADDR_ASYNC) begin
			async_r <= wb_i.dat[7:0] & 8'((1 << ASYNC_AS_BIT) | (1 << ASYNC_EXT_BIT));
		end
	end
	assign timer_external_clock_select_o = async_r[ASYNC_EXT_BIT];

	// RULE16: timer oscillator only while RC is the system clock
	assign timer_osc_en_o = async_r[ASYNC_AS_BIT] && (src == SRC_RC);

	assign status = {1'b0, ce_cnt_r != 3'h0, timer_osc_en_o, 2'(src), fuse_error_o,
		state_r == ST_SLEEP, core_clk_en_o};

	// Read data is registered; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !ack_r) begin
			unique case (wb_i.adr)
				ADDR_TRIM:   wb_dat_o <= {24'h00_0000, trim_r};
				ADDR_PRESC:  wb_dat_o <= {24'h00_0000, ce_cnt_r != 3'h0, 3'h0, presc_r};
				ADDR_ASYNC:  wb_dat_o <= {24'h00_0000, async_r};
				ADDR_STATUS: wb_dat_o <= {24'h00_0000, status};
				ADDR_CALIB:  wb_dat_o <= {16'h0000, factory_trim_5v_i, factory_trim_3v_i};
				default:     wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and clock output
	// ----------------------------------------------------------------
	// RULE15: output follows the divided clock
	ckss_clk_div u_div (
		.clk_i      (clk_i),
		.por_i      (por_i),
		.src_lvl_i  (src_lvl),
		.src_rise_i (src_rise),
		.div_sel_i  (presc_r),
		.clk_o      (sys_clk_o)
	);

	// RULE13: fuse overrides the port pin with the clock
	// RULE14: independent of chip reset, so it toggles during reset
	assign clock_output_pin_o    = fuses_r.clk_out & sys_clk_o;
	assign clock_output_pin_oe_o = fuses_r.clk_out;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	trim_load_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE3
		rst_i |=> trim_r == $past(factory_trim_3v_i)) else $error("trim not loaded in reset");
	trim_write_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i) // RULE4
		(wr && wb_i.adr == ADDR_TRIM) |=> rc_trim_register_o == $past(wb_i.dat[7:0]))
		else $error("trim write lost");
	src_rc_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE2
		fuses_r.src_sel == CODE_RC |-> rc_osc_en_o && !lp_osc_en_o) else $error("rc not selected");
	wake_count_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i) // RULE6
		(state_r == ST_WAKE && src_rise && ck_cnt_r == WAKE_CK - 4'h1) |=> core_clk_en_o)
		else $error("wake delay wrong");
	early_run_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i) // RULE11
		(state_r == ST_DLY_CK && ck_cnt_r < RESET_CK - 4'h1) |=> !core_clk_en_o)
		else $error("core released early");
	stretch_dly_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE7
		(rst_i && fuses_r.rst_dis && fuses_r.stup == STUP_BOD) |=> ms_target_r == MS_CNT_W'(TICKS_4P1MS))
		else $error("reset delay not stretched");
	clk_out_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE14
		fuses_r.clk_out |-> clock_output_pin_oe_o && clock_output_pin_o == sys_clk_o)
		else $error("clock output not driven");
	presc_rst_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE19
		rst_i |=> presc_r == (fuses_r.div8 ? PRESC_DIV8 : PRESC_DIV1)) else $error("bad prescaler reset");
	div_pass_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE15
		(presc_r == PRESC_DIV1 && $stable(presc_r)) |=> sys_clk_o == $past(src_lvl))
		else $error("undivided clock wrong");
	timer_osc_a: assert property (@(posedge clk_i) disable iff (por_i) // RULE16
		timer_osc_en_o |-> src == SRC_RC) else $error("timer osc without rc");

	run_reached_c: cover property (@(posedge clk_i) disable iff (rst_i || por_i) $rose(core_clk_en_o));
	wake_c: cover property (@(posedge clk_i) disable iff (rst_i || por_i) state_r == ST_WAKE ##1 core_clk_en_o);
	presc_change_c: cover property (@(posedge clk_i) disable iff (rst_i || por_i) $changed(presc_r));
endmodule

/* tb/ckss_osc_model.sv */
// ------------------------------------------------
// Oscillator and external clock stand-in
// ------------------------------------------------
module ckss_osc_model (
	input  wire logic clk_i,   // System clock
	input  wire logic rc_en_i, // RC enable
	input  wire logic lp_en_i, // 128kHz enable
	output logic      rc_o,    // RC level
	output logic      lp_o,    // 128kHz level
	output logic      ext_o,   // External clock level
	output logic      wdt_o    // Watchdog level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_r = 4'h0;

	// Halves of 2 clk or more, so the synchroniser never misses one
	always @(posedge clk_i) begin
		cnt_r <= cnt_r + 4'h1;
	end
	// RC runs only while enabled, period 4 clk
	assign rc_o = rc_en_i & cnt_r[1];
	assign lp_o = lp_en_i & cnt_r[2];
	// steady external clock, period 16 clk, no jumps
	assign ext_o = cnt_r[3];
	// watchdog runs apart from the chosen source
	assign wdt_o = cnt_r[2];
endmodule

/* tb/clock_source_select_startup_tb.sv */
module clock_source_select_startup_tb
	import ckss_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] T3 = 8'h5a;
	localparam logic [7:0] T5 = 8'ha3;
	logic         clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, pd = 1'b0;
	ckss_fuse_s   fuses = '0;
	ckss_wb_req_s wb = '0;
	logic [31:0]  rdat, wb_dat;
	logic [7:0]   trim;
	logic         ack, rc_en, lp_en, rc, lp, ext, wdt, sclk, creset, cen, co, co_oe, t_en, t_ext, ferr;
	int           bad_count = 0;
	int           tests_run = 0;
	int           c;

	ckss_top #(.T_64MS_TICKS(16), .T_65MS_TICKS(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.fuses_i(fuses), .factory_trim_3v_i(T3), .factory_trim_5v_i(T5), .rc_osc_i(rc), .lp_osc_i(lp),
		.crystal_input_pin_i(ext), .wdt_osc_i(wdt), .power_down_i(pd), .wb_i(wb), .wb_dat_o(wb_dat),
		.wb_ack_o(ack), .rc_trim_register_o(trim), .rc_osc_en_o(rc_en), .lp_osc_en_o(lp_en),
		.sys_clk_o(sclk), .core_reset_o(creset), .core_clk_en_o(cen), .clock_output_pin_o(co),
		.clock_output_pin_oe_o(co_oe), .timer_osc_en_o(t_en), .timer_external_clock_select_o(t_ext),
		.fuse_error_o(ferr));
	ckss_osc_model osc (.clk_i(clk_i), .rc_en_i(rc_en), .lp_en_i(lp_en), .rc_o(rc), .lp_o(lp),
		.ext_o(ext), .wdt_o(wdt));

	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hung waits end the run as a mismatch
	task automatic give_up(input string what);
		$display("BAD timeout %s", what);
		bad_count++;
		complete_run();
	endtask

	// Classic single cycle, entered just after a rising edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			give_up("bus");
		rdat = wb_dat;
		wb <= '0;
		@(posedge clk_i);
	endtask

	// Chip reset outlasts power-on reset by one cycle, so the plain reset path runs too
	task automatic por_with(input logic [3:0] s, input logic [1:0] stup, input logic d8, rd, ck);
		fuses <= '{s, stup, d8, rd, ck};
		por_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		por_i <= 1'b0;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_run(output int n);
		n = 0;
		while (cen !== 1'b1 && n < 8000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 8000)
			give_up("run");
	endtask

	task automatic wait_co(input logic v, inout int n);
		while (co !== v && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// Period of the clock output pin in system cycles
	task automatic co_period(output int p);
		int n;
		n = 0;
		wait_co(1'b0, n);
		wait_co(1'b1, n);
		p = n;
		wait_co(1'b0, n);
		wait_co(1'b1, n);
		p = n - p;
		if (n >= 3000)
			give_up("clock out");
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_startup();
		por_with(CODE_RC, STUP_BOD, 1'b1, 1'b0, 1'b1);
		check("rc enable", {rc_en, lp_en}, 2'b10); // RC chosen
		check("clk out enable", co_oe, 1'b1); // pin taken over
		wait_run(c);
		check("bare reset delay", c >= 52 && c < 100, 1'b1); // 14 source edges
		check("trim after reset", trim, T3); // trim
		bus(1'b0, ADDR_PRESC, '0);
		check("presc reset div8", rdat, PRESC_DIV8); // divide start
		co_period(c);
		check("divided clk out", c, 32); // divided output
	endtask

	task automatic t_presc();
		bus(1'b1, ADDR_PRESC, 32'h05);
		bus(1'b1, ADDR_PRESC, 32'h80);
		bus(1'b1, ADDR_PRESC, 32'h09);
		bus(1'b0, ADDR_PRESC, '0);
		check("presc refused", rdat, PRESC_DIV8); // value kept
		bus(1'b1, ADDR_PRESC, 32'h80);
		bus(1'b1, ADDR_PRESC, 32'h00);
		bus(1'b0, ADDR_PRESC, '0);
		check("presc div1", rdat, PRESC_DIV1); // new setting
		co_period(c);
		check("undivided clk out", c, 4); // output follows
	endtask

	task automatic t_regs();
		bus(1'b0, ADDR_CALIB, '0);
		check("trim bytes", rdat, {16'h0, T5, T3}); // alternate byte
		bus(1'b1, ADDR_TRIM, {24'h0, T5});
		bus(1'b0, ADDR_TRIM, '0);
		check("trim readback", rdat, {24'h0, T5}); // rewrite
		check("trim pin", trim, T5); // retune
		bus(1'b1, 8'h20, 32'hff);
		bus(1'b0, 8'h20, '0);
		check("unmapped", rdat, 32'h0); // no stray write
		check("trim kept", trim, T5); // trim untouched
		bus(1'b1, ADDR_ASYNC, 32'h60);
		check("timer osc", {t_en, t_ext}, 2'b11); // timer pins
	endtask

	// Reset in mid-run: output must keep running, trim reloads
	task automatic t_reset();
		int   tg;
		logic prev;
		rst_i <= 1'b1;
		@(posedge clk_i);
		c = 0;
		tg = 0;
		prev = co;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_i);
			c += int'(co !== sclk);
			tg += int'(co !== prev);
			prev = co;
		end
		check("held in reset", creset, 1'b1); // core held
		check("clk out mismatch", c, 0); // output follows clock
		check("clk out toggles", tg > 0, 1'b1); // runs in reset
		check("trim reload", trim, T3); // trim
		check("async cleared", t_ext, 1'b0); // reset clear
		rst_i <= 1'b0;
		@(posedge clk_i);
		wait_run(c);
		pd <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("asleep", cen, 1'b0); // power-down entered
		pd <= 1'b0;
		@(posedge clk_i);
		wait_run(c);
		check("wake delay", c >= 20 && c < 50, 1'b1); // six edges
	endtask

	task automatic t_sources();
		logic [3:0] s[2] = '{CODE_LP, CODE_EXT};
		int p[2] = '{8, 16};
		for (int i = 0; i < 2; i++) begin
			por_with(s[i], STUP_SLOW, 1'b0, 1'b0, 1'b1);
			check("lp enable", lp_en, i == 0); // source choice
			wait_run(c);
			co_period(c);
			check("source period", c, p[i]);
			bus(1'b1, ADDR_ASYNC, 32'h20);
			check("timer osc off", t_en, 1'b0); // RC only
		end
		por_with(CODE_RC, STUP_RSVD, 1'b0, 1'b0, 1'b0);
		check("reserved sut", ferr, 1'b1); // code 11
		por_with(CODE_RC, STUP_BOD, 1'b0, 1'b1, 1'b0);
		check("clk out off", co_oe, 1'b0); // fuse clear
		wait_run(c);
		check("stretched delay", c >= 4200, 1'b1); // longer delay
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		t_startup();
		t_presc();
		t_regs();
		t_reset();
		t_sources();
		complete_run();
	end
endmodule
